/* verilog/clbat_pkg.sv */
/*
  Shared constants and types for the card local-bus arbiter and timers.
  Assumes a 100 MHz APB clock and a 10 MHz timer reference input.
*/
package clbat_pkg;

  // ----------------------------------------------------------------
  // Clocks and times
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned GUARD_MS = 4;
  // One step per lit or dark phase, about fifty pairs in all
  localparam int unsigned BLINK_STEP_MS = 320;
  localparam int unsigned BLINK_SPAN_S = 32;
  // Counts are in reference ticks, not pclk cycles
  localparam int unsigned TICK_CNT = REF_HZ / 1000 * TICK_MS;
  localparam int unsigned GUARD_CNT = REF_HZ / 1000 * GUARD_MS;
  localparam int unsigned BLINK_HALF_CNT =
    REF_HZ / 1000 * BLINK_STEP_MS;
  localparam int unsigned BLINK_HALVES =
    BLINK_SPAN_S * 1000 / BLINK_STEP_MS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h00c;

  localparam int unsigned CB_NV_CS = 0;
  localparam int unsigned CB_NV_SCLK = 1;
  localparam int unsigned CB_NV_DIN = 2;
  localparam int unsigned CB_TICK_EN = 3;
  localparam int unsigned CB_GUARD_EN = 4;
  localparam int unsigned CB_TEST_LED = 5;
  localparam int unsigned CB_TEST_DONE = 6;
  localparam int unsigned CB_BLINK_GO = 7;
  localparam int unsigned CB_CLR_TICK = 8;
  localparam int unsigned CB_CLR_GUARD = 9;
  localparam int unsigned CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;

  localparam int unsigned SB_MAU_PWR = 0;
  localparam int unsigned SB_NV_DOUT = 1;
  localparam int unsigned SB_BLINK = 2;
  localparam int unsigned SB_GREEN = 3;
  localparam int unsigned SB_OWNER = 4;
  localparam int unsigned SB_TXERR = 8;
  localparam int unsigned TXERR_W = 4;

  localparam int unsigned IRQ_TICK = 0;
  localparam int unsigned IRQ_GUARD = 1;
  localparam int unsigned IRQ_TXERR = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Local RAM partition
  // ----------------------------------------------------------------
  localparam int unsigned RAM_BYTES = 65536;
  localparam int unsigned NV_BYTES = 32;
  localparam int unsigned RX_BUFS = 32;
  localparam int unsigned TX_BUFS = 8;
  localparam int unsigned BUF_BYTES = 1536;
  localparam logic [16:0] RX_END = 17'(RX_BUFS * BUF_BYTES);
  localparam logic [16:0] TX_END = 17'(RX_BUFS * BUF_BYTES
                                       + TX_BUFS * BUF_BYTES);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic net;
    logic dma;
    logic cpu;
  } clbat_req_t;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic din;
  } clbat_nv_t;

  typedef struct packed {
    logic rx;
    logic tx;
    logic other;
  } clbat_region_t;

  typedef enum logic [1:0] {
    OWN_IDLE = 2'b00,
    OWN_CPU = 2'b01,
    OWN_DMA = 2'b10,
    OWN_NET = 2'b11
  } clbat_owner_t;

endpackage : clbat_pkg

/* verilog/clbat_ref_timer.sv */
/*
  Reference-tick interval timer: pulses once per LIMIT ticks while run.
  Assumes ref_tick is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/1ps
module clbat_ref_timer #(
  parameter int unsigned LIMIT = 100,
  parameter int unsigned W = $clog2(LIMIT + 1)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic ref_tick,
  output logic expire
);
  import clbat_pkg::*;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [W-1:0] count;
  wire at_end = count == W'(LIMIT - 1);
  wire [W-1:0] next_count = !run ? '0
                          : !ref_tick ? count
                          : at_end ? '0
                          : count + W'(1);

  // Dropping run restarts the interval from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      count <= next_count;
      expire <= run & ref_tick & at_end;
    end
  end

endmodule : clbat_ref_timer

/* verilog/clbat_arbiter.sv */
/*
  Fixed-priority owner tracker for the shared local memory bus.
  Assumes cyc_busy is high while the owner's bus cycle is in progress.
*/
`timescale 1ns/1ps
module clbat_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input clbat_pkg::clbat_req_t req,
  input wire logic cyc_busy,
  output clbat_pkg::clbat_req_t grant,
  output clbat_pkg::clbat_owner_t owner
);
  import clbat_pkg::*;

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  clbat_owner_t pick;
  clbat_owner_t next_owner;
  logic owner_req;

  assign pick = req.net ? OWN_NET
              : req.dma ? OWN_DMA
              : req.cpu ? OWN_CPU : OWN_IDLE;

  always_comb begin
    next_owner = owner;
    owner_req = 1'b0;
    unique case (owner)
      OWN_IDLE: begin
        next_owner = pick;
      end
      OWN_CPU, OWN_DMA: begin
        owner_req = (owner == OWN_CPU) ? req.cpu : req.dma;
        // Never cut a cycle short; yield only between cycles
        if (!cyc_busy && (req.net || !owner_req)) begin
          next_owner = pick;
        end
      end
      OWN_NET: begin
        if (!cyc_busy && !req.net) begin
          next_owner = pick;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner <= OWN_IDLE;
    end else begin
      owner <= next_owner;
    end
  end

  // One-hot from a single state, so two grants can never meet
  assign grant.net = owner == OWN_NET;
  assign grant.dma = owner == OWN_DMA;
  assign grant.cpu = owner == OWN_CPU;

endmodule : clbat_arbiter

/* verilog/clbat_top.sv */
/*
  Card local-bus arbiter, tick and transmit-guard timers, control and
  status registers, indicator LEDs, reached over APB.
  Assumes all inputs synchronous to pclk; ref_clk_10m is a sampled level.
*/
// Design decisions made here: the register offsets and the APB register port.
//
// Function
// - Arbiter grants the shared bus to one requester
// - Network controller always wins simultaneous requests
// - Owner finishes current cycle, then yields to network
// - Both timers count the 10 MHz reference
// - Periodic interrupt every 10 ms while enabled
// - Interrupt after transmitting over 4 ms continuously
// - Control bits drive config memory, timers, test LED
// - Status shows attachment power and transmit errors
// - RAM holds 32 receive, 8 transmit buffers
// - 32-byte nonvolatile memory keeps node address
// - Green LED lit after self-test while powered
// - Loopback failure blinks red, 320 ms, 32 s
//
`timescale 1ns/1ps
module clbat_top #(
  parameter int unsigned TICK_LIMIT = clbat_pkg::TICK_CNT,
  parameter int unsigned GUARD_LIMIT = clbat_pkg::GUARD_CNT,
  parameter int unsigned BLINK_LIMIT = clbat_pkg::BLINK_HALF_CNT,
  parameter int unsigned BLINK_TOGGLES = clbat_pkg::BLINK_HALVES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clbat_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_10m,
  input clbat_pkg::clbat_req_t req,
  input wire logic cyc_busy,
  output clbat_pkg::clbat_req_t grant,
  input wire logic [15:0] local_addr,
  output clbat_pkg::clbat_region_t region,
  input wire logic tx_active,
  input wire logic [clbat_pkg::TXERR_W-1:0] tx_err,
  input wire logic mau_power,
  input wire logic nv_dout,
  output clbat_pkg::clbat_nv_t nv,
  output logic led_red,
  output logic led_green,
  output logic irq
);
  import clbat_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int unsigned BW = $clog2(BLINK_TOGGLES + 1);

  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [TXERR_W-1:0] txerr_lat;
  logic ref_d;
  logic ref_tick;
  logic tick_exp;
  logic guard_exp;
  logic blink_exp;
  logic blink_on;
  logic blink_phase;
  logic [BW-1:0] blink_left;
  clbat_owner_t owner;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = paddr == CTRL_OFF;
  wire hit_stat = paddr == STATUS_OFF;
  wire hit_istat = paddr == IRQ_STAT_OFF;
  wire hit_imask = paddr == IRQ_MASK_OFF;
  wire mapped = hit_ctrl | hit_stat | hit_istat | hit_imask;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_stat = wr & hit_stat;
  wire wr_istat = wr & hit_istat;
  wire wr_imask = wr & hit_imask;

  // Read data is latched in setup, so the slave never stalls
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Action bits act on the write and are not stored
  wire blink_go = wr_ctrl & pwdata[CB_BLINK_GO];
  wire clr_tick = wr_ctrl & pwdata[CB_CLR_TICK];
  wire clr_guard = wr_ctrl & pwdata[CB_CLR_GUARD];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end

  // Serial lines of the 32-byte node-address store
  assign nv.cs = ctrl[CB_NV_CS];
  assign nv.sclk = ctrl[CB_NV_SCLK];
  assign nv.din = ctrl[CB_NV_DIN];

  // ----------------------------------------------------------------
  // Reference tick
  // ----------------------------------------------------------------
  // Rising edge of the 10 MHz reference, one pclk wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= ref_clk_10m;
    end
  end

  assign ref_tick = ref_clk_10m & ~ref_d;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  clbat_ref_timer #(
    .LIMIT(TICK_LIMIT)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl[CB_TICK_EN]),
    .ref_tick(ref_tick),
    .expire(tick_exp)
  );

  // Falling transmit clears the count, so each burst is timed afresh
  clbat_ref_timer #(
    .LIMIT(GUARD_LIMIT)
  ) u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl[CB_GUARD_EN] & tx_active),
    .ref_tick(ref_tick),
    .expire(guard_exp)
  );

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [IRQ_W-1:0] irq_set = {|tx_err, guard_exp, tick_exp};
  wire [IRQ_W-1:0] irq_clr =
    (wr_istat ? pwdata[IRQ_W-1:0] : '0) | {1'b0, clr_guard, clr_tick};
  // Set beats clear, so an expiry on the clearing write survives
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_imask) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // Transmit error capture
  // ----------------------------------------------------------------
  wire [TXERR_W-1:0] txerr_clr =
    wr_stat ? pwdata[SB_TXERR +: TXERR_W] : '0;
  wire [TXERR_W-1:0] next_txerr = (txerr_lat & ~txerr_clr) | tx_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txerr_lat <= '0;
    end else begin
      txerr_lat <= next_txerr;
    end
  end

  // ----------------------------------------------------------------
  // Loopback failure blink
  // ----------------------------------------------------------------
  clbat_ref_timer #(
    .LIMIT(BLINK_LIMIT)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .run(blink_on),
    .ref_tick(ref_tick),
    .expire(blink_exp)
  );

  wire blink_last = blink_left == BW'(1);

  // A new request reloads the 32 s count of halves, lit first; u_blink is not restarted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_on <= 1'b0;
      blink_phase <= 1'b0;
      blink_left <= '0;
    end else if (blink_go) begin
      blink_on <= 1'b1;
      blink_phase <= 1'b1;
      blink_left <= BW'(BLINK_TOGGLES);
    end else if (blink_on && blink_exp) begin
      blink_phase <= ~blink_phase;
      blink_left <= blink_left - BW'(1);
      blink_on <= ~blink_last;
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  wire green = ctrl[CB_TEST_DONE] & mau_power;
  wire red = blink_on ? blink_phase : ctrl[CB_TEST_LED];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_red <= 1'b0;
      led_green <= 1'b0;
    end else begin
      led_red <= red;
      led_green <= green;
    end
  end

  // ----------------------------------------------------------------
  // Local bus arbitration
  // ----------------------------------------------------------------
  clbat_arbiter u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .cyc_busy(cyc_busy),
    .grant(grant),
    .owner(owner)
  );

  // ----------------------------------------------------------------
  // Local RAM partition
  // ----------------------------------------------------------------
  // Receive ring first, transmit ring next, the rest for firmware
  wire [16:0] la = {1'b0, local_addr};
  assign region.rx = la < RX_END;
  assign region.tx = (la >= RX_END) & (la < TX_END);
  assign region.other = la >= TX_END;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = '0;
    status_word[SB_MAU_PWR] = mau_power;
    status_word[SB_NV_DOUT] = nv_dout;
    status_word[SB_BLINK] = blink_on;
    status_word[SB_GREEN] = green;
    status_word[SB_OWNER +: 2] = owner;
    status_word[SB_TXERR +: TXERR_W] = txerr_lat;
  end

  assign rd_mux = hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl}
                : hit_stat ? status_word
                : hit_istat ? {{(32 - IRQ_W){1'b0}}, irq_stat}
                : hit_imask ? {{(32 - IRQ_W){1'b0}}, irq_mask}
                : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= rd_mux;
      pslverr <= ~mapped;
    end
  end

endmodule : clbat_top

/* bench/clbat_props.sv */
/*
  Checker for the local-bus arbiter, control pins and address map.
  Assumes it is bound to clbat_top and sees only its ports.
*/
`timescale 1ns/1ps
module clbat_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clbat_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input clbat_pkg::clbat_req_t req,
  input wire logic cyc_busy,
  input clbat_pkg::clbat_req_t grant,
  input wire logic [15:0] local_addr,
  input clbat_pkg::clbat_region_t region,
  input wire logic mau_power,
  input clbat_pkg::clbat_nv_t nv,
  input wire logic led_green
);
  import clbat_pkg::*;
  wire [16:0] la = {1'b0, local_addr};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------
  // Arbitration
  // --------------------------------
  sequence s_idle_net;
    grant == 3'b000 && req.net;
  endsequence
  sequence s_free_net;
    (grant.cpu || grant.dma) && req.net && !cyc_busy;
  endsequence
  AST_ONE_GRANT: assert property ($onehot0(grant))
    else $error("more than one grant");
  AST_NET_FIRST: assert property (s_idle_net |=> grant.net)
    else $error("network not granted first");
  AST_DMA_OVER_CPU: assert property
    (grant == 3'b000 && req.dma && !req.net |=> grant.dma)
    else $error("dma lost to processor");
  AST_YIELD_NET: assert property (s_free_net |=> grant.net)
    else $error("owner did not yield");
  AST_HOLD_BUSY: assert property
    ((grant.cpu || grant.dma) && cyc_busy |=> grant == $past(grant))
    else $error("grant moved inside a cycle");
  AST_CPU_DROP: assert property
    (grant.cpu && !req.cpu && !cyc_busy |=> !grant.cpu)
    else $error("grant kept without request");
  // --------------------------------
  // Pins and map
  // --------------------------------
  AST_NV_WRITE: assert property
    (psel && penable && pwrite && paddr == CTRL_OFF |=>
     nv == {$past(pwdata[0]), $past(pwdata[1]), $past(pwdata[2])})
    else $error("config memory pins wrong");
  AST_REGION_MAP: assert property (region == {la < RX_END,
    la >= RX_END && la < TX_END, la >= TX_END})
    else $error("region decode wrong");
  AST_GREEN_PWR: assert property (!mau_power [*2] |=> !led_green)
    else $error("green lit without power");
endmodule : clbat_props

bind clbat_top clbat_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .req(req), .cyc_busy(cyc_busy), .grant(grant),
  .local_addr(local_addr), .region(region), .mau_power(mau_power),
  .nv(nv), .led_green(led_green));

/* bench/clbat_masters.sv */
/*
  Three local-bus masters: processor, DMA and network controller.
  Assumes the bench chooses who wants the bus and the cycle length.
*/
`timescale 1ns/1ps
module clbat_masters (
  input wire logic pclk,
  input wire logic presetn,
  input clbat_pkg::clbat_req_t want,
  input wire logic [3:0] cyc_len,
  input clbat_pkg::clbat_req_t grant,
  output clbat_pkg::clbat_req_t req,
  output logic cyc_busy
);
  import clbat_pkg::*;
  logic [3:0] left;
  // A cycle once begun runs out; a slow cycle delays preemption
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
      cyc_busy <= 1'b0;
      left <= '0;
    end else begin
      req <= want;
      if (cyc_busy) begin
        left <= left - 4'h1;
        cyc_busy <= (left > 4'h1);
      // A preempted owner starts no new cycle
      end else if ((grant & req) != 3'b000 && (grant.net || !req.net)) begin
        left <= cyc_len;
        cyc_busy <= 1'b1;
      end
    end
  end
endmodule : clbat_masters

/* bench/tb_top.sv */
/*
  Self-checking bench: APB master, masters model, timer reference.
  Assumes shortened timer parameters and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  import clbat_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, cyc_busy, led_red, led_green, irq;
  logic ref_clk_10m = 1'b0;
  logic tx_active = 1'b0;
  logic mau_power = 1'b0;
  logic nv_dout = 1'b0;
  logic [3:0] tx_err = '0;
  logic [3:0] cyc_len = 4'h2;
  logic [15:0] local_addr = '0;
  logic [15:0] edges [4] = '{16'hbfff, 16'hc000, 16'hefff, 16'hf000};
  clbat_req_t want = '0;
  clbat_req_t req, grant;
  clbat_region_t region;
  clbat_nv_t nv;
  int n_fail = 0;
  int check_count = 0;
  int refc = 0;
  int k, v;

  initial begin
    forever #5 pclk = ~pclk;
  end
  // 10 MHz reference: ten pclk periods; addresses favour boundaries
  always @(posedge pclk) begin
    refc <= (refc == 4) ? 0 : refc + 1;
    if (refc == 4) ref_clk_10m <= ~ref_clk_10m;
    local_addr <= ($urandom & 1) ? 16'($urandom) : edges[$urandom % 4];
  end

  clbat_top #(.TICK_LIMIT(10), .GUARD_LIMIT(8), .BLINK_LIMIT(4),
    .BLINK_TOGGLES(6)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_10m(ref_clk_10m), .req(req),
    .cyc_busy(cyc_busy), .grant(grant), .local_addr(local_addr),
    .region(region), .tx_active(tx_active), .tx_err(tx_err),
    .mau_power(mau_power), .nv_dout(nv_dout), .nv(nv),
    .led_red(led_red), .led_green(led_green), .irq(irq));
  clbat_masters u_mst (.pclk(pclk), .presetn(presetn), .want(want),
    .cyc_len(cyc_len), .grant(grant), .req(req), .cyc_busy(cyc_busy));

  // --------------------------------
  // Model and tasks
  // --------------------------------
  function automatic clbat_req_t prio(clbat_req_t w);
    return w.net ? 3'b100 : w.dma ? 3'b010 : w.cpu ? 3'b001 : 3'b000;
  endfunction : prio
  function automatic clbat_region_t rmap(logic [15:0] a);
    return {{1'b0, a} < RX_END, {1'b0, a} >= RX_END && {1'b0, a} < TX_END,
      {1'b0, a} >= TX_END};
  endfunction : rmap
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rq, output logic re);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask : rd_chk
  task wait_idle;
    @(posedge pclk);
    want <= '0;
    for (k = 0; k < 40 && grant !== 3'b000; k++) @(posedge pclk);
  endtask : wait_idle
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    #100us;
    n_fail++;
    summarize();
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    void'($urandom(95595));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl reset", CTRL_OFF, 32'h0);
    rd_chk("mask reset", IRQ_MASK_OFF, 32'h0);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped", 32'h1, e);
    v = $urandom & 7;
    wr(CTRL_OFF, v);
    mau_power <= 1'b1;
    nv_dout <= 1'($urandom);
    @(negedge pclk);
    chk("nv pins", {v[0], v[1], v[2]}, nv);
    rd_chk("ctrl back", CTRL_OFF, v);
    rd_chk("status", STATUS_OFF, {nv_dout, 1'b1});
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      wait_idle();
      cyc_len <= 4'(1 + $urandom % 5);
      want <= clbat_req_t'(3'(i));
      repeat (3) @(negedge pclk);
      chk("grant", prio(clbat_req_t'(3'(i))), grant);
      chk("region", rmap(local_addr), region);
    end
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    chk("owner", 32'h3, q[5:4]);
    wait_idle();
    cyc_len <= 4'h6;
    want <= 3'b001;
    for (k = 0; k < 40 && !(cyc_busy === 1'b1 && grant.cpu === 1'b1); k++)
      @(negedge pclk);
    @(posedge pclk);
    want <= 3'b101;
    for (k = 0; k < 10 && cyc_busy === 1'b1; k++) begin
      @(negedge pclk);
      chk("hold", 32'h1, grant);
    end
    @(negedge pclk);
    chk("preempt", 32'h4, grant);
    $display("arbiter done");
    wait_idle();
    wr(IRQ_MASK_OFF, 32'h1);
    wr(CTRL_OFF, 32'h8);
    repeat (80) @(negedge pclk);
    chk("tick early", 32'h0, irq);
    repeat (40) @(negedge pclk);
    chk("tick", 32'h1, irq);
    wr(IRQ_MASK_OFF, 32'h0);
    @(negedge pclk);
    chk("masked", 32'h0, irq);
    wr(CTRL_OFF, 32'h0);
    rd_chk("sticky", IRQ_STAT_OFF, 32'h1);
    wr(CTRL_OFF, 32'h100);
    rd_chk("tick clr", IRQ_STAT_OFF, 32'h0);
    wr(IRQ_MASK_OFF, 32'h2);
    wr(CTRL_OFF, 32'h10);
    tx_active <= 1'b1;
    repeat (60) @(posedge pclk);
    tx_active <= 1'b0;
    repeat (20) @(posedge pclk);
    tx_active <= 1'b1;
    repeat (60) @(posedge pclk);
    rd_chk("guard early", IRQ_STAT_OFF, 32'h0);
    repeat (40) @(negedge pclk);
    chk("guard", 32'h1, irq);
    wr(CTRL_OFF, 32'h200);
    tx_active <= 1'b0;
    rd_chk("guard clr", IRQ_STAT_OFF, 32'h0);
    $display("timers done");
    v = 1 + $urandom % 15;
    @(posedge pclk);
    tx_err <= v[3:0];
    @(posedge pclk);
    tx_err <= 4'h0;
    wr(IRQ_MASK_OFF, 32'h4);
    @(negedge pclk);
    chk("err irq", 32'h1, irq);
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    chk("tx err", v, q[11:8]);
    wr(STATUS_OFF, 32'hf00);
    wr(IRQ_STAT_OFF, 32'h4);
    rd_chk("err clr", IRQ_STAT_OFF, 32'h0);
    wr(CTRL_OFF, 32'h40);
    repeat (3) @(negedge pclk);
    chk("green", 32'h1, led_green);
    @(posedge pclk);
    mau_power <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("green off", 32'h0, led_green);
    wr(CTRL_OFF, 32'he0);
    repeat (2) @(negedge pclk);
    chk("red on", 32'h1, led_red);
    repeat (58) @(negedge pclk);
    chk("red toggled", 32'h0, led_red);
    repeat (500) @(negedge pclk);
    chk("red steady", 32'h1, led_red);
    rd_chk("blink end", STATUS_OFF, {nv_dout, 1'b0});
    $display("leds done");
    summarize();
  end
endmodule : tb_top
